// ---- usrx_pkg.sv ----
// Constants for the synchronous master receive path and its baud divisor.
// Assumes an 8-bit register port addressed at the printed byte offsets.
package usrx_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] USRX_OFS_IRQ_FLAGS = 8'h0c;
	localparam logic [7:0] USRX_OFS_RX_STATUS = 8'h18;
	localparam logic [7:0] USRX_OFS_RX_FIFO = 8'h1a;
	localparam logic [7:0] USRX_OFS_IRQ_ENABLES = 8'h8c;
	localparam logic [7:0] USRX_OFS_TX_STATUS = 8'h98;
	localparam logic [7:0] USRX_OFS_BAUD_DIV = 8'h99;

	// ==========================================================
	// Reset values
	localparam logic [7:0] USRX_RST_IRQ_ENABLES = 8'h00;
	localparam logic [7:0] USRX_RST_TX_STATUS = 8'h02;
	localparam logic [7:0] USRX_RST_BAUD_DIV = 8'h00;
	localparam logic [7:0] USRX_RST_RDATA = 8'h00;

	// ==========================================================
	// Field positions
	localparam int USRX_BIT_RECEIVE_FLAG = 5;
	localparam int USRX_BIT_RECEIVE_IRQ_EN = 5;
	localparam int USRX_BIT_SERIAL_PORT_EN = 7;
	localparam int USRX_BIT_NINE_BIT_EN = 6;
	localparam int USRX_BIT_SINGLE_RX_EN = 5;
	localparam int USRX_BIT_CONT_RX_EN = 4;
	localparam int USRX_BIT_FRAMING_ERR = 2;
	localparam int USRX_BIT_OVERRUN_ERR = 1;
	localparam int USRX_BIT_NINTH_RX = 0;
	localparam int USRX_BIT_CLOCK_MASTER = 7;
	localparam int USRX_BIT_SYNC_SELECT = 4;
	localparam int USRX_BIT_HIGH_SPEED = 2;
	localparam int USRX_BIT_TX_EMPTY = 1;
	// Writable bits of the transmit status register kept by this block.
	localparam logic [7:0] USRX_TX_STATUS_WMASK = 8'hf5;

	// ==========================================================
	// Baud prescale counts in baud timer periods
	localparam logic [5:0] USRX_ASYNC_LOW_LAST = 6'h3f;
	localparam logic [5:0] USRX_ASYNC_HIGH_LAST = 6'h0f;
	localparam logic [5:0] USRX_SYNC_HALF_LAST = 6'h01;

	// ==========================================================
	// Word length
	localparam logic [3:0] USRX_LAST_BIT_8 = 4'h7;
	localparam logic [3:0] USRX_LAST_BIT_9 = 4'h8;

	typedef enum logic [0:0] {
		USRX_IDLE = 1'b0,
		USRX_SHIFT = 1'b1
	} usrx_state_t;

endpackage

// ---- usrx_baud_if.sv ----
// Carrier between the receiver core and its baud generator.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface usrx_baud_if;
	logic [7:0] divisor;
	logic restart;
	logic high_speed;
	logic sync_mode;
	logic half_tick;
	logic async_tick;
	modport ctrl (output divisor, restart, high_speed, sync_mode,
		input half_tick, async_tick);
	modport gen (input divisor, restart, high_speed, sync_mode,
		output half_tick, async_tick);
endinterface
`default_nettype wire

// ---- usrx_baud_gen.sv ----
// Baud generator: free-running 8-bit timer plus bit-rate prescaler.
// Assumes restart is a one-cycle pulse on every divisor write.
`timescale 1ns/1ps
`default_nettype none
module usrx_baud_gen (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Link to the receiver core
	usrx_baud_if.gen bif
);
	import usrx_pkg::*;

	logic [7:0] timer_q;
	logic [5:0] pre_q;
	logic period_end;
	logic [5:0] pre_last;

	// ==========================================================
	// Timer
	// The timer period is divisor+1 clocks, covering 1 to 256.
	assign period_end = (timer_q == bif.divisor);

	// A divisor write clears the timer so the new rate starts at once.
	always_ff @(posedge sys_clk) begin
		if (!rstn || bif.restart) begin
			timer_q <= 8'h00;
		end else if (period_end) begin
			timer_q <= 8'h00;
		end else begin
			timer_q <= timer_q + 8'h01;
		end
	end

	// ==========================================================
	// Prescaler
	// The high-speed select only matters for asynchronous rates.
	always_comb begin
		if (bif.sync_mode) begin
			pre_last = USRX_SYNC_HALF_LAST;
		end else if (bif.high_speed) begin
			pre_last = USRX_ASYNC_HIGH_LAST;
		end else begin
			pre_last = USRX_ASYNC_LOW_LAST;
		end
	end

	// Two timer periods make a half bit clock, hence four per bit.
	always_ff @(posedge sys_clk) begin
		if (!rstn || bif.restart) begin
			pre_q <= 6'h00;
			bif.half_tick <= 1'b0;
			bif.async_tick <= 1'b0;
		end else begin
			bif.half_tick <= 1'b0;
			bif.async_tick <= 1'b0;
			if (period_end) begin
				if (pre_q >= pre_last) begin
					pre_q <= 6'h00;
					bif.half_tick <= bif.sync_mode;
					bif.async_tick <= !bif.sync_mode;
				end else begin
					pre_q <= pre_q + 6'h01;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ---- usrx_sync_rx.sv ----
// Synchronous master receive path with divisor, FIFO and status bits.
// Assumes a one-cycle register port and a transmitter outside that
// presents each bit before the shift clock falls.
//
// Operation
// - Asynchronous bit rate is clock over 64 or 16 times divisor+1.
// - Synchronous bit clock is clock over 4 times divisor+1.
// - Divisor is a full unsigned 8-bit value from its register.
// - In synchronous mode either receive enable starts reception.
// - Each data bit is sampled at the falling shift clock edge.
// - Single-receive enable takes exactly one word, then stops.
// - Continuous enable receives words until software clears it.
// - With both enables set, continuous reception wins.
// - Completed word enters the FIFO if room, then receive flag sets.
// - Receive flag is read-only and clears once the FIFO is empty.
// - Interrupt request is the receive flag gated by its enable.
// - Receive data is a two-entry FIFO behind the shift register.
// - A word completing into a full FIFO sets overrun and is lost.
// - Overrun is cleared only by clearing continuous enable.
// - While overrun is set no word enters the FIFO.
// - Ninth bit is queued per word; each read shows the next one.
// - Baud generator is a free-running 8-bit timer.
// - Writing the divisor clears the baud timer at once.
`timescale 1ns/1ps
`default_nettype none
module usrx_sync_rx (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	// Serial pins
	input wire logic serial_data_pin_in,
	output logic shift_clk_out,
	output logic shift_clk_oe,
	// Events
	output logic receive_irq,
	output logic async_bit_tick
);
	import usrx_pkg::*;

	// The baud generator sits behind one carrier so its rate inputs and
	// tick outputs stay together; the core alone owns the divisor.
	usrx_baud_if bif ();

	// Control registers.
	logic [7:0] irq_enables_q;
	logic [7:0] tx_status_q;
	logic [7:0] baud_divisor_q;
	logic serial_port_enable_q;
	logic nine_bit_receive_enable_q;
	logic single_receive_enable_q;
	logic continuous_receive_enable_q;
	logic overrun_error_q;
	// Receiver state.
	usrx_state_t state_q;
	logic [3:0] bit_cnt_q;
	logic [8:0] receive_shift_register_q;
	logic word_done_q;
	// FIFO state.
	logic [8:0] fifo_mem_q [2];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] fifo_cnt_q;
	// Output flops.
	logic [7:0] rd_data_q;
	logic shift_clk_q;
	logic shift_clk_oe_q;
	logic receive_irq_q;
	logic async_bit_tick_q;
	// Decodes.
	logic wr_rx_status;
	logic rd_fifo;
	logic sync_master;
	logic run_ok;
	logic fifo_full;
	logic push;
	logic pop;
	logic receive_flag;
	logic ninth_received_bit;
	logic [3:0] last_bit;
	logic [7:0] rx_status_view;
	logic [7:0] tx_status_view;

	// Write and read strobes that more than one process uses.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	// ==========================================================
	// Baud generator
	assign bif.divisor = baud_divisor_q;
	assign bif.restart = wr_en && hit(addr, USRX_OFS_BAUD_DIV);
	assign bif.high_speed = tx_status_q[USRX_BIT_HIGH_SPEED];
	assign bif.sync_mode = tx_status_q[USRX_BIT_SYNC_SELECT];

	usrx_baud_gen u_baud (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.bif(bif)
	);

	// ==========================================================
	// Decodes
	assign wr_rx_status = wr_en && hit(addr, USRX_OFS_RX_STATUS);
	assign rd_fifo = rd_en && hit(addr, USRX_OFS_RX_FIFO);
	assign sync_master = serial_port_enable_q &&
		tx_status_q[USRX_BIT_SYNC_SELECT] &&
		tx_status_q[USRX_BIT_CLOCK_MASTER];
	// Either enable starts reception; abort follows when all drop.
	assign run_ok = sync_master && (single_receive_enable_q ||
		continuous_receive_enable_q);
	// Count runs 0 to 2; a full FIFO is two stored words, never three.
	assign fifo_full = (fifo_cnt_q == 2'h2);
	assign pop = rd_fifo && (fifo_cnt_q != 2'h0);
	// A read in the same cycle frees a slot, so the word still fits.
	assign push = word_done_q && !overrun_error_q &&
		(!fifo_full || pop);
	assign receive_flag = (fifo_cnt_q != 2'h0);
	assign ninth_received_bit = fifo_mem_q[rd_ptr_q][8];
	assign last_bit = nine_bit_receive_enable_q ? USRX_LAST_BIT_9 :
		USRX_LAST_BIT_8;

	// ==========================================================
	// Register writes
	// Writes to the flag register, the FIFO and the status-only bits
	// land nowhere, so software cannot fake a received word or clear
	// an overrun without dropping the continuous enable.
	// Plain read-write registers.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			irq_enables_q <= USRX_RST_IRQ_ENABLES;
			tx_status_q <= USRX_RST_TX_STATUS;
			baud_divisor_q <= USRX_RST_BAUD_DIV;
		end else if (wr_en) begin
			if (hit(addr, USRX_OFS_IRQ_ENABLES)) begin
				irq_enables_q <= wr_data;
			end
			if (hit(addr, USRX_OFS_TX_STATUS)) begin
				tx_status_q <= wr_data & USRX_TX_STATUS_WMASK;
			end
			if (hit(addr, USRX_OFS_BAUD_DIV)) begin
				baud_divisor_q <= wr_data;
			end
		end
	end

	// Receive control bits; the single enable self-clears after a word unless continuous is set.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			serial_port_enable_q <= 1'b0;
			nine_bit_receive_enable_q <= 1'b0;
			single_receive_enable_q <= 1'b0;
			continuous_receive_enable_q <= 1'b0;
		end else if (wr_rx_status) begin
			serial_port_enable_q <= wr_data[USRX_BIT_SERIAL_PORT_EN];
			nine_bit_receive_enable_q <= wr_data[USRX_BIT_NINE_BIT_EN];
			single_receive_enable_q <= wr_data[USRX_BIT_SINGLE_RX_EN];
			continuous_receive_enable_q <= wr_data[USRX_BIT_CONT_RX_EN];
		end else if (word_done_q && !continuous_receive_enable_q) begin
			single_receive_enable_q <= 1'b0;
		end
	end

	// Overrun sets when a word finds the FIFO full; software cannot
	// write it and clears it only by dropping the continuous enable.
	// A word finishing in the clearing cycle still sets it.
	// Letting the set win means an overrun is never lost to a clear
	// that software issued a moment too early.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			overrun_error_q <= 1'b0;
		end else if (word_done_q && fifo_full && !pop) begin
			overrun_error_q <= 1'b1;
		end else if (!continuous_receive_enable_q) begin
			overrun_error_q <= 1'b0;
		end
	end

	// ==========================================================
	// Shift engine
	// The clock idles low, rises on one half tick and falls on the next.
	// Data is taken at the fall, so the sender has the high half to
	// settle the bit. Dropping any qualifier abandons a partial word.
	// The limitation is that a partial word is gone for good: the
	// sender must start over from bit 0 after any abort.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state_q <= USRX_IDLE;
			shift_clk_q <= 1'b0;
			bit_cnt_q <= 4'h0;
			receive_shift_register_q <= 9'h000;
			word_done_q <= 1'b0;
		end else begin
			word_done_q <= 1'b0;
			if (!run_ok) begin
				state_q <= USRX_IDLE;
				shift_clk_q <= 1'b0;
				bit_cnt_q <= 4'h0;
			end else begin
				case (state_q)
					USRX_IDLE: begin
						if (bif.half_tick) begin
							state_q <= USRX_SHIFT;
							shift_clk_q <= 1'b1;
							bit_cnt_q <= 4'h0;
							receive_shift_register_q <= 9'h000;
						end
					end
					USRX_SHIFT: begin
						if (bif.half_tick && !shift_clk_q) begin
							shift_clk_q <= 1'b1;
						end else if (bif.half_tick) begin
							shift_clk_q <= 1'b0;
							receive_shift_register_q[bit_cnt_q] <=
								serial_data_pin_in;
							if (bit_cnt_q == last_bit) begin
								word_done_q <= 1'b1;
								bit_cnt_q <= 4'h0;
								// Continuous enable overrides single.
								if (!continuous_receive_enable_q) begin
									state_q <= USRX_IDLE;
								end // else stays for next word
							end else begin
								bit_cnt_q <= bit_cnt_q + 4'h1;
							end
						end
					end
					default: begin
						state_q <= USRX_IDLE;
						shift_clk_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Receive FIFO
	// Two entries of nine bits: the ninth bit travels with its word.
	// Pointers are one bit each and the count is kept beside them, so
	// full and empty never have to be told apart from equal pointers.
	// A push and a pop in one cycle leave the count where it was.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			fifo_mem_q[0] <= 9'h000;
			fifo_mem_q[1] <= 9'h000;
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			fifo_cnt_q <= 2'h0;
		end else begin
			if (push) begin
				fifo_mem_q[wr_ptr_q] <= receive_shift_register_q;
				wr_ptr_q <= !wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= !rd_ptr_q;
			end
			if (push && !pop) begin
				fifo_cnt_q <= fifo_cnt_q + 2'h1;
			end else if (pop && !push) begin
				fifo_cnt_q <= fifo_cnt_q - 2'h1;
			end
		end
	end

	// ==========================================================
	// Register reads
	// The framing error never sets in synchronous reception.
	// The ninth-bit field shows the head entry, so it moves on with
	// every pop; software must read it before the data to keep it.
	always_comb begin
		rx_status_view = 8'h00;
		rx_status_view[USRX_BIT_SERIAL_PORT_EN] = serial_port_enable_q;
		rx_status_view[USRX_BIT_NINE_BIT_EN] = nine_bit_receive_enable_q;
		rx_status_view[USRX_BIT_SINGLE_RX_EN] = single_receive_enable_q;
		rx_status_view[USRX_BIT_CONT_RX_EN] = continuous_receive_enable_q;
		rx_status_view[USRX_BIT_FRAMING_ERR] = 1'b0;
		rx_status_view[USRX_BIT_OVERRUN_ERR] = overrun_error_q;
		rx_status_view[USRX_BIT_NINTH_RX] = ninth_received_bit;
		tx_status_view = tx_status_q;
		// No transmitter here, so its shift register always reads empty.
		tx_status_view[USRX_BIT_TX_EMPTY] = 1'b1;
	end

	// Read data stands one cycle after the strobe; unmapped reads zero.
	// Returning zero between reads keeps stale data off the bus, at
	// the cost of one flop update every idle cycle.
	// An empty FIFO read returns the old head and pops nothing.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rd_data_q <= USRX_RST_RDATA;
		end else if (rd_en) begin
			case (addr)
				USRX_OFS_IRQ_FLAGS: begin
					rd_data_q <= 8'h00;
					rd_data_q[USRX_BIT_RECEIVE_FLAG] <= receive_flag;
				end
				USRX_OFS_RX_STATUS: rd_data_q <= rx_status_view;
				USRX_OFS_RX_FIFO: rd_data_q <= fifo_mem_q[rd_ptr_q][7:0];
				USRX_OFS_IRQ_ENABLES: rd_data_q <= irq_enables_q;
				USRX_OFS_TX_STATUS: rd_data_q <= tx_status_view;
				USRX_OFS_BAUD_DIV: rd_data_q <= baud_divisor_q;
				default: rd_data_q <= 8'h00;
			endcase
		end else begin
			rd_data_q <= 8'h00;
		end
	end

	// ==========================================================
	// Output flops
	// The clock pin is enabled only for a configured master.
	// The enable follows the mode bits, not the run state, so the pin
	// holds its idle low level between words instead of floating.
	// The interrupt request lags the flag by one cycle, a fair price
	// for an output that comes straight from a flop.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			shift_clk_oe_q <= 1'b0;
			receive_irq_q <= 1'b0;
			async_bit_tick_q <= 1'b0;
		end else begin
			shift_clk_oe_q <= sync_master;
			receive_irq_q <= receive_flag &&
				irq_enables_q[USRX_BIT_RECEIVE_IRQ_EN];
			async_bit_tick_q <= bif.async_tick;
		end
	end

	// Every top output below is a flop; no logic sits after them.
	assign rd_data = rd_data_q;
	assign shift_clk_out = shift_clk_q;
	assign shift_clk_oe = shift_clk_oe_q;
	assign receive_irq = receive_irq_q;
	assign async_bit_tick = async_bit_tick_q;

endmodule
`default_nettype wire

// ---- usrx_sync_rx_monitor.sv ----
// Port checker for the synchronous master receive path.
// Assumes a single system clock and the one-cycle register port.
`timescale 1ns/1ps
`default_nettype none
module usrx_sync_rx_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rd_data,
	// Serial pins and events
	input wire logic serial_data_pin_in,
	input wire logic shift_clk_out,
	input wire logic shift_clk_oe,
	input wire logic receive_irq,
	input wire logic async_bit_tick
);
	// ==========================================================
	// Shadow of the control bits software has written
	logic [7:0] div_q;
	logic ien_q, rc7_q, rc4_q, tx7_q, tx4_q, clk_q, vld_q;
	logic [9:0] run_q;
	logic cfg, tgl;
	logic [9:0] half;

	// Pin enable condition, clock edges and the expected half period.
	assign cfg = rc7_q & tx7_q & tx4_q;
	assign tgl = shift_clk_out != clk_q;
	assign half = ({2'b00, div_q} + 10'h001) << 1;

	// Bits follow register writes on the same edge as the design.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			div_q <= 8'h00;
			{ien_q, rc7_q, rc4_q, tx7_q, tx4_q} <= 5'h00;
		end else if (wr_en) begin
			case (addr)
			8'h99: div_q <= wr_data;
			8'h8c: ien_q <= wr_data[5];
			8'h18: {rc7_q, rc4_q} <= {wr_data[7], wr_data[4]};
			8'h98: {tx7_q, tx4_q} <= {wr_data[7], wr_data[4]};
			default: ;
			endcase
		end
	end

	// Run length of the shift clock. Any receive status, transmit status or divisor write voids the run,
	// since a start, an abort or a new divisor may shorten it legally.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			clk_q <= 1'b0;
			run_q <= 10'h000;
			vld_q <= 1'b0;
		end else begin
			clk_q <= shift_clk_out;
			run_q <= tgl ? 10'h001 : run_q + 10'h001;
			if (wr_en && addr inside {8'h18, 8'h98, 8'h99})
				vld_q <= 1'b0;
			else if (tgl)
				vld_q <= 1'b1;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence flag_rd;
		rd_en && addr == 8'h0c && ien_q;
	endsequence
	sequence sync_off;
		wr_en && addr == 8'h98 && !wr_data[4];
	endsequence

	irq_mask_a: assert property (receive_irq |-> $past(ien_q))
		else $error("irq raised while its enable was clear");
	irq_flag_a: assert property (flag_rd |=> receive_irq == rd_data[5])
		else $error("irq differs from the receive flag");
	oe_cfg_a: assert property (shift_clk_oe == $past(cfg))
		else $error("clock enable does not follow the mode bits");
	clk_idle_a: assert property (!shift_clk_oe
		&& !$past(shift_clk_oe) |-> !shift_clk_out)
		else $error("shift clock high while not driven");
	half_time_a: assert property (vld_q && tgl |-> run_q == half)
		else $error("shift clock half period wrong");
	abort_a: assert property (sync_off |=> ##1
		!shift_clk_out && !shift_clk_oe)
		else $error("reception not stopped by mode change");
	// A word ending into a full FIFO sets overrun for one cycle even
	// with the continuous enable clear, so a fall just before is excused.
	ovr_clear_a: assert property (rd_en && addr == 8'h18
		&& !rc4_q && !$past(rc4_q) && ($past(shift_clk_out)
		|| !$past(shift_clk_out, 2)) |=> !rd_data[1])
		else $error("overrun kept with continuous enable clear");
	async_off_a: assert property (tx4_q && $past(tx4_q)
		&& $past(tx4_q, 2) |-> !async_bit_tick)
		else $error("async tick in synchronous mode");
endmodule

bind usrx_sync_rx usrx_sync_rx_monitor usrx_sync_rx_monitor_inst (
	.sys_clk, .rstn, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
	.serial_data_pin_in, .shift_clk_out, .shift_clk_oe, .receive_irq,
	.async_bit_tick
);
`default_nettype wire

// ---- usrx_tx_model.sv ----
// Model of the external synchronous transmitter on the data pin.
// Assumes the receiver drives the shift clock, LSB first.
`timescale 1ns/1ps
`default_nettype none
module usrx_tx_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Word to send, its last bit index and a restart strobe
	input wire logic [8:0] word,
	input wire logic [3:0] last_bit,
	input wire logic load,
	// Serial pins
	input wire logic shift_clk,
	output logic sdata
);
	logic clk_q;
	logic [3:0] idx_q;

	// A bit goes out just after each rise, settled before the fall.
	// After the fall the hold is over, so the line flips rather than
	// keeping a stale level the receiver could get away with.
	always_ff @(posedge sys_clk) begin
		clk_q <= shift_clk;
		if (!rstn || load) begin
			idx_q <= 4'h0;
			sdata <= 1'b0;
		end else if (shift_clk && !clk_q) begin
			sdata <= word[idx_q];
		end else if (!shift_clk && clk_q) begin
			idx_q <= (idx_q == last_bit) ? 4'h0 : idx_q + 4'h1;
			sdata <= ~sdata;
		end
	end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the synchronous master receive path.
// Assumes the checker is bound and the transmitter model is present.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
	n_mismatch++; $display("[ERR] %s exp %h seen %h", n, e, g); end end
module testbench;
	logic sys_clk, rstn, wr_en, rd_en, load, sdin, sclk, soe, irq, atick;
	logic [7:0] addr, wr_data, rd_data, v, c;
	logic [8:0] word;
	logic [3:0] lastb;
	int n_mismatch, tests_run, i;
	logic [7:0] ra [7] = '{8'h0c, 8'h18, 8'h1a, 8'h8c, 8'h98, 8'h99, 8'h55};
	logic [7:0] re [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};

	// 40 MHz system clock.
	always #12.5 sys_clk = ~sys_clk;

	usrx_sync_rx usrx_sync_rx_inst (.sys_clk, .rstn, .addr, .wr_data,
		.wr_en, .rd_en, .rd_data, .serial_data_pin_in(sdin),
		.shift_clk_out(sclk), .shift_clk_oe(soe), .receive_irq(irq),
		.async_bit_tick(atick));
	usrx_tx_model usrx_tx_model_inst (.sys_clk, .rstn, .word,
		.last_bit(lastb), .load, .shift_clk(sclk), .sdata(sdin));

	// ==========================================================
	// Register port tasks; each leaves one idle edge behind it.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1 v = rd_data;
		@(posedge sys_clk);
	endtask
	task automatic rc(input string n, input logic [7:0] a,
		input logic [7:0] e, input logic [7:0] m = 8'hff);
		rd(a);
		`CHK(n, e, v & m)
	endtask
	task automatic arm(input logic [8:0] w, input logic [3:0] lb);
		word <= w;
		lastb <= lb;
		load <= 1'b1;
		@(posedge sys_clk);
		load <= 1'b0;
		@(posedge sys_clk);
	endtask
	// A word that never completes must not hang the run.
	task automatic wait_irq;
		for (i = 0; i < 300 && irq !== 1'b1; i++) @(posedge sys_clk);
		if (i == 300) begin
			n_mismatch++;
			close_out;
		end
	endtask
	// Cycles between two async ticks, bounded so a dead divider ends.
	task automatic arate(input logic [7:0] ts, input int e);
		wr(8'h98, ts);
		wr(8'h99, 8'h00);
		for (i = 0; i < 200 && atick !== 1'b1; i++) @(posedge sys_clk);
		@(posedge sys_clk);
		for (i = 1; i < 200 && atick !== 1'b1; i++) @(posedge sys_clk);
		`CHK("async rate", e, i)
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{sys_clk, rstn, wr_en, rd_en, load} = 5'h00;
		{addr, wr_data, word, lastb} = 29'h0000007;
		n_mismatch = 0;
		tests_run = 0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		// Reset values, the last offset is unmapped and reads zero.
		for (int k = 0; k < 7; k++) rc("reset", ra[k], re[k]);
		wr(8'h99, 8'hff);
		rc("divisor", 8'h99, 8'hff);
		wr(8'h98, 8'hff);
		rc("tx status", 8'h98, 8'hf7);
		// Software order: divisor, mode bits, irq enable, then receive.
		wr(8'h99, 8'h01);
		wr(8'h98, 8'h90);
		wr(8'h8c, 8'h20);
		arm(9'h0a5, 4'h7);
		wr(8'h18, 8'ha0);
		wait_irq;
		wr(8'h0c, 8'h00);
		rc("flag", 8'h0c, 8'h20);
		wr(8'h8c, 8'h00);
		#1 `CHK("irq masked", 1'b0, irq)
		@(posedge sys_clk);
		wr(8'h8c, 8'h20);
		#1 `CHK("irq", 1'b1, irq)
		@(posedge sys_clk);
		rc("single done", 8'h18, 8'h80);
		rc("word", 8'h1a, 8'ha5);
		rc("flag clear", 8'h0c, 8'h00);
		c = 8'h00;
		repeat (40) begin
			@(posedge sys_clk);
			c += {7'h00, sclk};
		end
		`CHK("clock stopped", 8'h00, c)
		// Both enables, nine bits: keeps receiving into an overrun.
		arm(9'h13c, 4'h8);
		wr(8'h18, 8'hf0);
		v = 8'h00;
		for (i = 0; i < 200 && v[1] !== 1'b1; i++) rd(8'h18);
		if (v[1] !== 1'b1) begin
			n_mismatch++;
			close_out;
		end
		rc("overrun", 8'h18, 8'hf3);
		wr(8'h18, 8'hf0);
		rc("ovr kept", 8'h18, 8'hf3);
		repeat (160) @(posedge sys_clk);
		rc("fifo 0", 8'h1a, 8'h3c);
		rc("ninth", 8'h18, 8'hf3);
		rc("fifo 1", 8'h1a, 8'h3c);
		repeat (160) @(posedge sys_clk);
		rc("blocked", 8'h0c, 8'h00);
		wr(8'h18, 8'hc0);
		rc("ovr clear", 8'h18, 8'hc0, 8'hfe);
		// Single nine-bit word whose ninth bit is clear.
		arm(9'h0c3, 4'h8);
		wr(8'h18, 8'he0);
		wait_irq;
		rc("ninth clear", 8'h18, 8'hc0);
		rc("word9", 8'h1a, 8'hc3);
		// Dropping sync select mid-word aborts it.
		arm(9'h0ff, 4'h7);
		wr(8'h18, 8'h90);
		repeat (20) @(posedge sys_clk);
		wr(8'h98, 8'h80);
		#1 `CHK("oe", 1'b0, soe)
		@(posedge sys_clk);
		repeat (80) @(posedge sys_clk);
		rc("aborted", 8'h0c, 8'h00);
		// Asynchronous rates from a zero divisor: 16 or 64 clocks a bit.
		arate(8'h04, 16);
		arate(8'h00, 64);
		close_out;
	end
endmodule
`default_nettype wire
